// File: sec_pkg.sv
// Constants, encodings and state record of the serial EEPROM command logic
package sec_pkg;
    localparam logic [3:0] DEV_CODE      = 4'ha;
    localparam int         ADDR_W        = 17;
    localparam int         PAGE_W        = 7;
    localparam int         PAGE_BYTES    = 128;
    localparam int         FIFO_DEPTH    = 16;
    localparam int         FIFO_W        = 15;
    localparam int         CNT_W         = 24;
    localparam int         CLK_PERIOD_NS = 40;
    localparam int         WRITE_TIME_NS = 5_000_000;
    localparam int         WRITE_CYCLES  = WRITE_TIME_NS / CLK_PERIOD_NS;
    // Control byte field positions
    localparam int         CTL_RW        = 0;
    localparam int         CTL_CS_LO     = 1;
    localparam int         CTL_CS_HI     = 2;
    localparam int         CTL_HALF      = 3;
    localparam int         CTL_CODE_LSB  = 4;
    // Bit counter values for last data bit and acknowledge slot
    localparam logic [3:0] BIT_LAST      = 4'h8;
    localparam logic [3:0] BIT_ACK       = 4'h9;

    typedef enum logic [6:0] {
        ST_IDLE   = 7'h01,
        ST_CTRL   = 7'h02,
        ST_ADDR_H = 7'h04,
        ST_ADDR_L = 7'h08,
        ST_WDATA  = 7'h10,
        ST_RDATA  = 7'h20,
        ST_IGNORE = 7'h40
    } sec_state_type;

    typedef enum logic [3:0] {
        CP_IDLE  = 4'h1,
        CP_DRAIN = 4'h2,
        CP_COPY  = 4'h4,
        CP_WAIT  = 4'h8
    } sec_commit_type;

    typedef struct packed {
        logic [1:0]          scl_sync;
        logic [1:0]          sda_sync;
        logic [1:0]          wp_sync;
        logic [1:0]          csl_sync;
        logic [1:0]          csh_sync;
        logic                scl_d;
        logic                sda_d;
        sec_state_type       st;
        logic [3:0]          bitcnt;
        logic [7:0]          shift;
        logic [7:0]          tx;
        logic                sda_oe_n;
        logic [ADDR_W-1:0]   ptr;
        logic [7:0]          busy_ctrl;
        logic [7:0]          cur_ctrl;
        logic                have_data;
        logic [ADDR_W-PAGE_W-1:0] page_base;
        logic [PAGE_BYTES-1:0] mask;
        sec_commit_type      cp;
        logic                discard;
        logic [PAGE_W:0]     cidx;
        logic [CNT_W-1:0]    wcnt;
    } sec_core_type;

    localparam sec_core_type CORE_RESET = '{
        scl_sync: 2'h3, sda_sync: 2'h3, wp_sync: 2'h0, csl_sync: 2'h0, csh_sync: 2'h0,
        scl_d: 1'b1, sda_d: 1'b1, st: ST_IDLE, bitcnt: 4'h0, shift: 8'h00, tx: 8'h00,
        sda_oe_n: 1'b1, ptr: '0, busy_ctrl: 8'h00, cur_ctrl: 8'h00, have_data: 1'b0,
        page_base: '0, mask: '0, cp: CP_IDLE, discard: 1'b0, cidx: '0, wcnt: '0};
endpackage

// File: sec_eeprom.sv
// Two-wire serial EEPROM slave: command decode, page buffer, write cycle, reads
`timescale 1ns/1ps

module sec_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_sys_in,
    input  wire logic             reset_n_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] wr;
        logic [AW:0] rd;
    } sec_fifo_type;

    sec_fifo_type           r;
    sec_fifo_type           next_r;
    logic [WIDTH-1:0]       store [0:DEPTH-1];
    logic                   push;
    logic                   pop;

    assign out_valid_out = (r.wr != r.rd);
    // Full when pointers differ only in the wrap bit
    assign in_ready_out  = (r.wr != {~r.rd[AW], r.rd[AW-1:0]});
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;
    assign out_data_out  = store[r.rd[AW-1:0]];

    always_comb
    begin
        next_r = r;
        if (push)
        begin
            next_r.wr = r.wr + 1'b1;
        end
        if (pop)
        begin
            next_r.rd = r.rd + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (push)
        begin
            store[r.wr[AW-1:0]] <= in_data_in;
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end
endmodule

module sec_eeprom
    import sec_pkg::*;
#(
    parameter int WRITE_CYCLE_COUNT = WRITE_CYCLES
) (
    input  wire logic              clk_sys_in,
    input  wire logic              reset_n_in,
    input  wire logic              scl_in,
    input  wire logic              sda_in,
    output logic                   sda_out,
    output logic                   sda_oe_n_out,
    input  wire logic              chip_select_low_pin_in,
    input  wire logic              chip_select_high_pin_in,
    input  wire logic              write_protect_in,
    output logic                   busy_out,
    output logic [ADDR_W-1:0]      addr_ptr_out
);
    localparam int MEM_BYTES = 2 ** ADDR_W;

    sec_core_type           r;
    sec_core_type           next_r;
    logic [7:0]             mem [0:MEM_BYTES-1];
    logic [7:0]             page_buf [0:PAGE_BYTES-1];
    logic [7:0]             mem_q;
    logic                   scl;
    logic                   sda;
    logic                   scl_rise;
    logic                   scl_fall;
    logic                   start_cond;
    logic                   stop_cond;
    logic                   fifo_in_valid;
    logic                   fifo_in_ready;
    logic [FIFO_W-1:0]      fifo_in_data;
    logic                   fifo_out_valid;
    logic                   fifo_out_ready;
    logic [FIFO_W-1:0]      fifo_out_data;
    logic                   addressed;

    // Page mode steps low seven bits; read mode steps sixteen, half bit held
    function automatic logic [ADDR_W-1:0] addr_step(input logic [ADDR_W-1:0] p, input logic page_mode);
        if (page_mode)
        begin
            addr_step = {p[ADDR_W-1:PAGE_W], p[PAGE_W-1:0] + 1'b1};
        end
        else
        begin
            addr_step = {p[ADDR_W-1], p[ADDR_W-2:0] + 1'b1};
        end
    endfunction

    assign scl        = r.scl_sync[1];
    assign sda        = r.sda_sync[1];
    assign scl_rise   = scl && !r.scl_d;
    assign scl_fall   = !scl && r.scl_d;
    assign start_cond = scl && r.scl_d && r.sda_d && !sda;
    assign stop_cond  = scl && r.scl_d && !r.sda_d && sda;

    assign sda_out      = 1'b0;
    assign sda_oe_n_out = r.sda_oe_n;
    assign addr_ptr_out = r.ptr;
    // A protected write drains its buffer silently and never reports busy
    assign busy_out     = (r.cp == CP_COPY) || (r.cp == CP_WAIT) || ((r.cp == CP_DRAIN) && !r.discard);

    assign addressed = (r.shift[7:CTL_CODE_LSB] == DEV_CODE)
                     && (r.shift[CTL_CS_HI] == r.csh_sync[1])
                     && (r.shift[CTL_CS_LO] == r.csl_sync[1]);

    assign fifo_in_data   = {r.ptr[PAGE_W-1:0], r.shift};
    assign fifo_in_valid  = scl_fall && (r.bitcnt == BIT_LAST) && (r.st == ST_WDATA);
    // Page buffer stays frozen while it is copied into the array
    assign fifo_out_ready = (r.cp != CP_COPY);

    sec_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_in    (clk_sys_in),
        .reset_n_in    (reset_n_in),
        .in_valid_in   (fifo_in_valid),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (fifo_in_data),
        .out_valid_out (fifo_out_valid),
        .out_ready_in  (fifo_out_ready),
        .out_data_out  (fifo_out_data)
    );

    always_comb
    begin
        next_r = r;
        next_r.scl_sync = {r.scl_sync[0], scl_in};
        next_r.sda_sync = {r.sda_sync[0], sda_in};
        next_r.wp_sync  = {r.wp_sync[0], write_protect_in};
        next_r.csl_sync = {r.csl_sync[0], chip_select_low_pin_in};
        next_r.csh_sync = {r.csh_sync[0], chip_select_high_pin_in};
        next_r.scl_d    = scl;
        next_r.sda_d    = sda;

        if (scl_rise && r.bitcnt < BIT_LAST)
        begin
            next_r.shift  = {r.shift[6:0], sda};
            next_r.bitcnt = r.bitcnt + 4'h1;
        end
        if (scl_rise && r.bitcnt == BIT_ACK && r.st == ST_RDATA && sda)
        begin
            next_r.st = ST_IGNORE;
        end

        if (scl_fall && r.bitcnt > 4'h0 && r.bitcnt < BIT_LAST && r.st == ST_RDATA)
        begin
            next_r.tx       = {r.tx[6:0], 1'b0};
            next_r.sda_oe_n = r.tx[6];
        end

        if (scl_fall && r.bitcnt == BIT_LAST)
        begin
            next_r.bitcnt   = BIT_ACK;
            next_r.sda_oe_n = 1'b1;
            case (r.st)
                ST_CTRL:
                begin
                    if (addressed && !(busy_out && r.shift == r.busy_ctrl))
                    begin
                        next_r.sda_oe_n = 1'b0;
                        next_r.cur_ctrl = r.shift;
                        next_r.ptr[ADDR_W-1] = r.shift[CTL_HALF];
                        next_r.st = r.shift[CTL_RW] ? ST_RDATA : ST_ADDR_H;
                    end
                    else
                    begin
                        next_r.st = ST_IGNORE;
                    end
                end
                ST_ADDR_H:
                begin
                    next_r.ptr[ADDR_W-2:8] = r.shift;
                    next_r.sda_oe_n        = 1'b0;
                    next_r.st              = ST_ADDR_L;
                end
                ST_ADDR_L:
                begin
                    next_r.ptr[7:0] = r.shift;
                    next_r.sda_oe_n = 1'b0;
                    next_r.st       = ST_WDATA;
                end
                ST_WDATA:
                begin
                    // A full buffer path refuses the byte with a NACK
                    if (fifo_in_ready)
                    begin
                        next_r.sda_oe_n = 1'b0;
                        next_r.ptr = addr_step(r.ptr, 1'b1);
                        if (!r.have_data)
                        begin
                            next_r.page_base = r.ptr[ADDR_W-1:PAGE_W];
                        end
                        next_r.have_data = 1'b1;
                    end
                    else
                    begin
                        next_r.st = ST_IGNORE;
                    end
                end
                ST_RDATA:
                begin
                    next_r.ptr = addr_step(r.ptr, 1'b0);
                end
                default:
                begin
                    next_r.sda_oe_n = 1'b1;
                end
            endcase
        end

        if (scl_fall && r.bitcnt == BIT_ACK)
        begin
            next_r.bitcnt   = 4'h0;
            next_r.sda_oe_n = 1'b1;
            if (r.st == ST_RDATA)
            begin
                next_r.tx       = mem_q;
                next_r.sda_oe_n = mem_q[7];
            end
        end

        if (fifo_out_valid && fifo_out_ready)
        begin
            next_r.mask[fifo_out_data[FIFO_W-1:8]] = 1'b1;
        end

        if (start_cond || stop_cond)
        begin
            next_r.bitcnt   = 4'h0;
            next_r.sda_oe_n = 1'b1;
            next_r.st       = start_cond ? ST_CTRL : ST_IDLE;
            next_r.have_data = 1'b0;
            if (r.have_data && r.st == ST_WDATA)
            begin
                next_r.cp        = CP_DRAIN;
                next_r.busy_ctrl = r.cur_ctrl;
                next_r.discard   = r.wp_sync[1] || start_cond;
            end
        end

        case (r.cp)
            CP_IDLE:
            begin
                next_r.cidx = '0;
            end
            CP_DRAIN:
            begin
                // Commit only once buffered data is in
                if (!fifo_out_valid)
                begin
                    next_r.cp = r.discard ? CP_IDLE : CP_COPY;
                    if (r.discard)
                    begin
                        next_r.mask = '0;
                    end
                end
            end
            CP_COPY:
            begin
                next_r.cidx = r.cidx + 1'b1;
                if (r.cidx == PAGE_BYTES[PAGE_W:0] - 1'b1)
                begin
                    next_r.cp   = CP_WAIT;
                    next_r.mask = '0;
                    next_r.wcnt = CNT_W'(WRITE_CYCLE_COUNT - 1);
                end
            end
            CP_WAIT:
            begin
                next_r.wcnt = r.wcnt - 1'b1;
                if (r.wcnt == '0)
                begin
                    next_r.cp = CP_IDLE;
                end
            end
            default:
            begin
                next_r.cp = CP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (fifo_out_valid && fifo_out_ready)
        begin
            page_buf[fifo_out_data[FIFO_W-1:8]] <= fifo_out_data[7:0];
        end
    end

    // Unwritten page bytes keep their contents, as a refresh would leave them
    always_ff @(posedge clk_sys_in)
    begin
        if (r.cp == CP_COPY && r.mask[r.cidx[PAGE_W-1:0]])
        begin
            mem[{r.page_base, r.cidx[PAGE_W-1:0]}] <= page_buf[r.cidx[PAGE_W-1:0]];
        end
        mem_q <= mem[r.ptr];
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            r <= CORE_RESET;
        end
        else
        begin
            r <= next_r;
        end
    end
endmodule

// File: sec_eeprom_asserts.sv
// Port-level concurrent checks of the serial EEPROM command logic
`timescale 1ns/1ps
module sec_eeprom_asserts
    import sec_pkg::*;
#(
    parameter int WRITE_CYCLE_COUNT = WRITE_CYCLES
) (
    input wire logic              clk_sys_in,
    input wire logic              reset_n_in,
    input wire logic              scl_in,
    input wire logic              sda_in,
    input wire logic              sda_out,
    input wire logic              sda_oe_n_out,
    input wire logic              chip_select_low_pin_in,
    input wire logic              chip_select_high_pin_in,
    input wire logic              write_protect_in,
    input wire logic              busy_out,
    input wire logic [ADDR_W-1:0] addr_ptr_out
);
    logic [4:0]       scl_high_cnt;
    logic [CNT_W-1:0] busy_len;
    // Saturating count of clock-high cycles marks an idle bus
    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            scl_high_cnt <= 5'h0;
            busy_len     <= '0;
        end
        else
        begin
            scl_high_cnt <= !scl_in ? 5'h0 : scl_high_cnt + 5'(scl_high_cnt != 5'h1f);
            busy_len     <= busy_out ? busy_len + 1'b1 : '0;
        end
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);
    property p_ack_low;
        !sda_oe_n_out |-> sda_out == 1'b0;
    endproperty
    a_ack_low: assert property (p_ack_low) else $error("driven data level not low");
    property p_oe_scl_low;
        $changed(sda_oe_n_out) |-> !$past(scl_in, 2);
    endproperty
    a_oe_scl_low: assert property (p_oe_scl_low) else $error("data drive moved with clock high");
    property p_idle_released;
        scl_high_cnt >= 5'h10 |-> sda_oe_n_out;
    endproperty
    a_idle_released: assert property (p_idle_released) else $error("data line held on idle bus");
    property p_busy_at_stop;
        $rose(busy_out) |-> scl_in && sda_in && sda_oe_n_out;
    endproperty
    a_busy_at_stop: assert property (p_busy_at_stop) else $error("write cycle began outside stop");
    property p_protect_no_busy;
        $rose(busy_out) |-> !write_protect_in && !$past(write_protect_in, 3);
    endproperty
    a_protect_no_busy: assert property (p_protect_no_busy) else $error("protected write ran");
    property p_busy_min;
        $fell(busy_out) |-> busy_len >= WRITE_CYCLE_COUNT;
    endproperty
    a_busy_min: assert property (p_busy_min) else $error("write cycle too short");
    property p_busy_max;
        busy_out |-> busy_len <= WRITE_CYCLE_COUNT + 400;
    endproperty
    a_busy_max: assert property (p_busy_max) else $error("write cycle too long");
    property p_ptr_idle;
        scl_high_cnt >= 5'h10 |-> $stable(addr_ptr_out);
    endproperty
    a_ptr_idle: assert property (p_ptr_idle) else $error("pointer moved on idle bus");
endmodule

bind sec_eeprom sec_eeprom_asserts #(.WRITE_CYCLE_COUNT(WRITE_CYCLE_COUNT)) u_asserts (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out), .chip_select_low_pin_in(chip_select_low_pin_in),
    .chip_select_high_pin_in(chip_select_high_pin_in), .write_protect_in(write_protect_in),
    .busy_out(busy_out), .addr_ptr_out(addr_ptr_out));

// File: sec_master.sv
// Behavioural two-wire bus master that clocks the device
`timescale 1ns/1ps
module sec_master (
    input  wire logic clk_sys_in,
    input  wire logic sda_line_in,
    output logic      scl_out,
    output logic      sda_low_out
);
    initial
    begin
        scl_out     = 1'b1;
        sda_low_out = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask
    // Data moves only mid clock-low; sampled mid clock-high
    task automatic bit_io(input logic b, output logic r);
        scl_out = 1'b0;
        tick(2);
        sda_low_out = !b;
        tick(2);
        scl_out = 1'b1;
        tick(2);
        r = sda_line_in;
        tick(2);
    endtask
    task automatic start();
        logic r;
        // A repeated start must first free the line in a clock-low phase, or a held ack masks the edge
        if (!scl_out || !sda_line_in || sda_low_out)
            bit_io(1'b1, r);
        sda_low_out = 1'b1;
        tick(4);
    endtask
    task automatic stop();
        logic r;
        bit_io(1'b0, r);
        sda_low_out = 1'b0;
        tick(8);
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic rbyte(output logic [7:0] d, input logic more);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(!more, r);
    endtask
endmodule

// File: tb_top.sv
// Self-checking bench of the serial EEPROM command logic
`timescale 1ns/1ps
module tb_top;
    import sec_pkg::*;
    localparam int WCC = 200;
    logic              clk_sys_in           = 1'b0;
    logic              reset_n_in           = 1'b0;
    logic              chip_select_low_pin  = 1'b1;
    logic              chip_select_high_pin = 1'b0;
    logic              write_protect        = 1'b0;
    logic              scl;
    logic              sda_low;
    logic              sda_out;
    logic              sda_oe_n;
    logic              busy;
    logic [ADDR_W-1:0] addr_ptr;
    int                fail_count   = 0;
    int                total_checks = 0;
    // Pull-up wins unless a party pulls low
    wire               sda_line = (sda_oe_n ? 1'b1 : sda_out) & !sda_low;
    always #20 clk_sys_in = !clk_sys_in;
    sec_master u_m (.clk_sys_in(clk_sys_in), .sda_line_in(sda_line), .scl_out(scl), .sda_low_out(sda_low));
    sec_eeprom #(.WRITE_CYCLE_COUNT(WCC)) dut (
        .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe_n_out(sda_oe_n), .chip_select_low_pin_in(chip_select_low_pin),
        .chip_select_high_pin_in(chip_select_high_pin), .write_protect_in(write_protect),
        .busy_out(busy), .addr_ptr_out(addr_ptr));
    task automatic conclude();
        if (fail_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        total_checks++;
        if (ok !== 1'b1)
        begin
            fail_count++;
            $display("Error at %0t: %s", $time, m);
        end
    endtask
    function automatic logic [7:0] ctl(input logic half, input logic rd);
        return {DEV_CODE, half, 2'b01, rd};
    endfunction
    task automatic send(input logic [7:0] b, input logic exp_ack, input string m);
        logic a;
        u_m.wbyte(b, a);
        chk(a === exp_ack, m);
    endtask
    task automatic addr_set(input logic [ADDR_W-1:0] a);
        u_m.start();
        send(ctl(a[16], 1'b0), 1'b1, "write control not acked");
        send(a[15:8], 1'b1, "high address not acked");
        send(a[7:0], 1'b1, "low address not acked");
    endtask
    task automatic close_write(input logic [ADDR_W-1:0] a, input logic prot, input logic wp_after);
        logic ack;
        int   n;
        u_m.stop();
        write_protect = wp_after;
        chk(busy === !prot, "busy after stop wrong");
        n = 0;
        do
        begin
            u_m.start();
            u_m.wbyte(ctl(a[16], 1'b0), ack);
            u_m.stop();
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        chk(ack === 1'b1 && (n == 1) === prot, "polling answer wrong");
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic prot, input logic wp_after);
        addr_set(a);
        send(d, 1'b1, "data not acked");
        close_write(a, prot, wp_after);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input int n, input logic [7:0] e [2]);
        logic [7:0] d;
        addr_set(a);
        u_m.start();
        send(ctl(a[16], 1'b1), 1'b1, "read control not acked");
        for (int i = 0; i < n; i++)
        begin
            u_m.rbyte(d, i < n - 1);
            chk(d === e[i], "read data wrong");
        end
        u_m.stop();
    endtask
    task automatic t_select();
        logic [7:0] bad [4] = '{8'hb2, 8'ha0, 8'ha6, 8'h22};
        foreach (bad[i])
        begin
            u_m.start();
            send(bad[i], 1'b0, "foreign control acked");
            send(8'h00, 1'b0, "ignored byte acked");
            u_m.stop();
        end
        // Pin levels decide the match, not a fixed code
        chip_select_high_pin = 1'b1;
        u_m.start();
        send(ctl(1'b0, 1'b0), 1'b0, "control acked against pin level");
        u_m.stop();
        u_m.start();
        send(8'ha6, 1'b1, "control matching pins not acked");
        u_m.stop();
        chip_select_high_pin = 1'b0;
    endtask
    task automatic t_bytes();
        logic [7:0] d;
        wr(17'h0_0005, 8'h5a, 1'b0, 1'b0);
        chk(addr_ptr === 17'h0_0006, "pointer after byte write");
        wr(17'h0_0006, 8'ha6, 1'b0, 1'b0);
        rd(17'h0_0005, 2, '{8'h5a, 8'ha6});
        rd(17'h0_0005, 1, '{8'h5a, 8'h00});
        chk(addr_ptr === 17'h0_0006, "pointer after random read");
        u_m.start();
        send(ctl(1'b0, 1'b1), 1'b1, "current read not acked");
        u_m.rbyte(d, 1'b0);
        u_m.stop();
        chk(d === 8'ha6 && addr_ptr === 17'h0_0007, "current read wrong");
    endtask
    task automatic t_protect();
        write_protect = 1'b1;
        wr(17'h0_0005, 8'hff, 1'b1, 1'b0);
        rd(17'h0_0005, 1, '{8'h5a, 8'h00});
        wr(17'h0_0005, 8'h77, 1'b0, 1'b1);
        write_protect = 1'b0;
        rd(17'h0_0005, 1, '{8'h77, 8'h00});
    endtask
    task automatic t_page();
        addr_set(17'h1_017e);
        for (int i = 0; i < 130; i++)
            send(8'(i), 1'b1, "page byte not acked");
        close_write(17'h1_017e, 1'b0, 1'b0);
        chk(addr_ptr === 17'h1_0100, "pointer after page write");
        rd(17'h1_017e, 2, '{8'h80, 8'h81});
        rd(17'h1_0100, 2, '{8'h02, 8'h03});
    endtask
    task automatic t_wrap();
        wr(17'h1_ffff, 8'hc3, 1'b0, 1'b0);
        wr(17'h1_0000, 8'h3c, 1'b0, 1'b0);
        wr(17'h0_ffff, 8'h99, 1'b0, 1'b0);
        wr(17'h0_0000, 8'h66, 1'b0, 1'b0);
        rd(17'h1_ffff, 2, '{8'hc3, 8'h3c});
        chk(addr_ptr === 17'h1_0001, "upper half wrap");
        rd(17'h0_ffff, 2, '{8'h99, 8'h66});
        chk(addr_ptr === 17'h0_0001, "lower half wrap");
    endtask
    initial
    begin
        repeat (12) @(negedge clk_sys_in);
        reset_n_in = 1'b1;
        repeat (4) @(negedge clk_sys_in);
        chk(busy === 1'b0 && addr_ptr === 17'h0_0000, "state after reset");
        t_select();
        t_bytes();
        t_protect();
        t_page();
        t_wrap();
        conclude();
    end
    initial
    begin
        repeat (60000) @(posedge clk_sys_in);
        fail_count++;
        $display("Error at %0t: run timed out", $time);
        conclude();
    end
endmodule
